// *** rtl/sdli_pkg.sv ***
// Package for the serial DAC load interface: widths, codes and carriers.
// Assumes a 16-bit data word and a model strap for the clear code.
package sdli_pkg;
  localparam int unsigned WORD_W = 16;
  localparam int unsigned CNT_W = 5;
  localparam logic [CNT_W-1:0] BITS_PER_WORD = 5'h10;
  localparam logic [WORD_W-1:0] CODE_ZERO = 16'h0000;
  localparam logic [WORD_W-1:0] CODE_MID = 16'h8000;
  localparam logic [WORD_W-1:0] RESET_CODE = 16'h0000;
  // Bit positions in the vector that crosses into clk_in
  localparam int unsigned SYNC_W = 5;
  localparam int unsigned SYNC_CLR_LVL = 0;
  localparam int unsigned SYNC_LOAD = 1;
  localparam int unsigned SYNC_WORD_TOG = 2;
  localparam int unsigned SYNC_CLR_TOG = 3;
  localparam int unsigned SYNC_SEL = 4;

  typedef enum logic {
    SDLI_ZEROSCALE,
    SDLI_MIDSCALE
  } sdli_clear_sel_t;

  typedef struct packed {
    logic cs_n;
    logic din;
  } sdli_link_t;

  typedef struct packed {
    logic [WORD_W-1:0] word;
    logic toggle;
  } sdli_word_xfer_t;
endpackage : sdli_pkg

// *** rtl/sdli_sync.sv ***
// Two-flop synchroniser for single-bit levels into the clk_in domain.
// Assumes the input is a level from another clock or from a pin.
`timescale 1ns/100ps
module sdli_sync #(
  parameter int unsigned WIDTH = 1
) (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1;

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      stage1 <= '0;
      sync_out <= '0;
    end else begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end
endmodule : sdli_sync

// *** rtl/sdli_top.sv ***
// Serial DAC load interface: shift register on the serial clock, input and
// DAC registers on clk_in, asynchronous clear and load strobe.
// Assumes the host keeps the serial clock duty cycle and frames words.
`timescale 1ns/100ps
module sdli_top (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic sclk_in,
  input wire sdli_pkg::sdli_link_t link_in,
  input wire logic dac_load_strobe_n_in,
  input wire logic async_clear_n_in,
  input wire sdli_pkg::sdli_clear_sel_t clear_sel_in,
  output logic [sdli_pkg::WORD_W-1:0] input_reg_out,
  output logic [sdli_pkg::WORD_W-1:0] dac_reg_out,
  output logic dac_update_out
);
  import sdli_pkg::*;

  // ==========================================================================
  // Link domain: shift register on the serial clock
  // ==========================================================================
  logic [WORD_W-1:0] shift;
  logic [CNT_W-1:0] bit_cnt;
  sdli_word_xfer_t xfer;
  logic frame_rst_n;
  logic [WORD_W-1:0] next_shift;
  logic [CNT_W-1:0] next_bit_cnt;
  wire cnt_full = (bit_cnt == BITS_PER_WORD);

  // Chip select high clears the count; this ends a frame without a clock
  assign frame_rst_n = ~link_in.cs_n & rstn_in;
  assign next_shift = {shift[WORD_W-2:0], link_in.din};
  assign next_bit_cnt = cnt_full ? bit_cnt : bit_cnt + 5'h01;

  always_ff @(posedge sclk_in or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      bit_cnt <= '0;
    end else begin
      bit_cnt <= next_bit_cnt;
    end
  end

  always_ff @(posedge sclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      shift <= '0;
    end else if (!link_in.cs_n && !cnt_full) begin
      shift <= next_shift;
    end
  end

  // Word is complete after sixteen bits; it is handed over when chip select
  // rises. The word register is captured at the rising edge of cs_n, which
  // acts as the frame's own closing edge since sclk may stop after it.
  logic word_done;
  assign word_done = cnt_full;

  always_ff @(posedge link_in.cs_n or negedge rstn_in) begin
    if (!rstn_in) begin
      xfer <= '{word: RESET_CODE, toggle: 1'b0};
    end else if (word_done) begin
      xfer.word <= shift;
      xfer.toggle <= ~xfer.toggle;
    end
  end

  // ==========================================================================
  // Crossing into clk_in: toggle plus stable word
  // ==========================================================================
  logic clr_tog;
  logic [SYNC_W-1:0] sync_in;
  logic [SYNC_W-1:0] sync_lv;

  // Each clear fall flips a toggle on the pin itself, so a pulse shorter
  // than a clk_in period is kept; reset and every second fall return it to zero
  always_ff @(negedge async_clear_n_in or negedge rstn_in) begin
    if (!rstn_in) begin
      clr_tog <= 1'b0;
    end else begin
      clr_tog <= ~clr_tog;
    end
  end

  // Strobe and clear are inverted so every bit resets to its idle level
  assign sync_in = {logic'(clear_sel_in), clr_tog, xfer.toggle,
    ~dac_load_strobe_n_in, ~async_clear_n_in};

  sdli_sync #(.WIDTH(SYNC_W)) u_sync (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .async_in(sync_in),
    .sync_out(sync_lv)
  );

  logic tog_seen;
  logic clr_tog_seen;
  logic load_seen;
  sdli_clear_sel_t sel_sync;
  wire word_event = sync_lv[SYNC_WORD_TOG] ^ tog_seen;
  wire load_active = sync_lv[SYNC_LOAD];
  wire load_fall = load_active & ~load_seen;
  wire clear_active = sync_lv[SYNC_CLR_LVL];
  assign sel_sync = sdli_clear_sel_t'(sync_lv[SYNC_SEL]);

  // ==========================================================================
  // Clear: caught asynchronously, applied for one clk_in cycle
  // ==========================================================================
  logic [WORD_W-1:0] clear_code;
  assign clear_code = (sel_sync == SDLI_MIDSCALE) ? CODE_MID : CODE_ZERO;

  wire clr_now = sync_lv[SYNC_CLR_TOG] ^ clr_tog_seen;
  // Loads are refused while clear is low and in the cycle it is applied
  wire clr_block = clr_now | clear_active;

  // ==========================================================================
  // Input and DAC registers
  // ==========================================================================
  logic [WORD_W-1:0] next_input;
  logic [WORD_W-1:0] next_dac;
  logic next_update;

  assign next_input = clr_now ? clear_code :
    (word_event ? xfer.word : input_reg_out);
  assign next_update = load_fall & ~clr_block;
  assign next_dac = clr_now ? clear_code :
    (next_update ? input_reg_out : dac_reg_out);

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      tog_seen <= 1'b0;
      clr_tog_seen <= 1'b0;
      load_seen <= 1'b0;
      input_reg_out <= RESET_CODE;
      dac_reg_out <= RESET_CODE;
      dac_update_out <= 1'b0;
    end else begin
      tog_seen <= sync_lv[SYNC_WORD_TOG];
      clr_tog_seen <= sync_lv[SYNC_CLR_TOG];
      load_seen <= load_active;
      input_reg_out <= next_input;
      dac_reg_out <= next_dac;
      dac_update_out <= next_update;
    end
  end
endmodule : sdli_top

// *** sim/sdli_host.sv ***
// Host model: frames words on the link, clock idle low outside frames
`timescale 1ns/100ps
module sdli_host (
  output logic sclk_out,
  output sdli_pkg::sdli_link_t link_out
);
  import sdli_pkg::*;
  initial begin
    sclk_out = 1'b0;
    link_out = 2'b10;
  end
  task automatic send(input logic [WORD_W-1:0] w, input int n);
    link_out.cs_n = 1'b0;
    for (int i = 0; i < n; i++) begin
      link_out.din = w[WORD_W-1-i];
      #15 sclk_out = 1'b1;
      #15 sclk_out = 1'b0;
    end
    #15 link_out.cs_n = 1'b1;
    link_out.din = ~link_out.din;
  endtask : send
endmodule : sdli_host

// *** sim/sdli_sva.sv ***
// Checker for the serial DAC load interface, bound to sdli_top
`timescale 1ns/100ps
module sdli_sva (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire sdli_pkg::sdli_link_t link_in,
  input wire logic dac_load_strobe_n_in,
  input wire logic async_clear_n_in,
  input wire sdli_pkg::sdli_clear_sel_t clear_sel_in,
  input wire logic [sdli_pkg::WORD_W-1:0] input_reg_out,
  input wire logic [sdli_pkg::WORD_W-1:0] dac_reg_out,
  input wire logic dac_update_out
);
  import sdli_pkg::*;
  wire clr = async_clear_n_in;
  wire [WORD_W-1:0] code = clear_sel_in ? CODE_MID : CODE_ZERO;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rstn_in);
  sequence s_load;
    $fell(dac_load_strobe_n_in) && clr ##1 clr[*2];
  endsequence
  a_update_once: assert property (dac_update_out |=> !dac_update_out)
    else $error("update pulse too long");
  a_load_copy: assert property (s_load |-> ##[0:2] dac_update_out)
    else $error("load not taken");
  a_copy_value: assert property (dac_update_out |->
    dac_reg_out == input_reg_out) else $error("dac differs from input");
  a_clear_blocks: assert property (!clr[*3] |-> !dac_update_out)
    else $error("load during clear");
  a_clear_code: assert property ($fell(clr) |-> ##[1:4]
    (input_reg_out == code && dac_reg_out == code)) else $error("clear code");
  a_latch_end: assert property ($changed(input_reg_out) && clr
    |-> link_in.cs_n) else $error("word in mid frame");
  a_frame_hold: assert property (!link_in.cs_n[*5]
    |-> $stable(input_reg_out)) else $error("input moved in frame");
  a_dac_source: assert property ($changed(dac_reg_out)
    |-> dac_update_out || dac_reg_out == code) else $error("dac moved alone");
endmodule : sdli_sva

// *** sim/sdli_top_test.sv ***
// Testbench: host model on the link, strobe and clear from the bench
`timescale 1ns/100ps
module sdli_top_test;
  import sdli_pkg::*;
  logic clk_in = 1'b0, rstn_in = 1'b0, ld_n = 1'b1, clr_n = 1'b1;
  logic sclk, upd;
  sdli_link_t link;
  sdli_clear_sel_t sel = SDLI_ZEROSCALE;
  logic [WORD_W-1:0] in_reg, dac_reg;
  int error_cnt = 0, checked = 0, cyc = 0, upd_cnt = 0;
  initial forever #12.5 clk_in = ~clk_in;
  sdli_host u_host (.sclk_out(sclk), .link_out(link));
  sdli_top u_dut (.clk_in(clk_in), .rstn_in(rstn_in), .sclk_in(sclk),
    .link_in(link), .dac_load_strobe_n_in(ld_n),
    .async_clear_n_in(clr_n), .clear_sel_in(sel),
    .input_reg_out(in_reg), .dac_reg_out(dac_reg), .dac_update_out(upd));
  always @(negedge clk_in) upd_cnt += (upd === 1'b1);
  always @(posedge clk_in) begin
    if (++cyc == 3000) begin
      error_cnt++;
      end_of_test();
    end
  end
  task automatic chk(string what, logic [WORD_W-1:0] got, exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s exp %h got %h", what, exp, got);
    end
  endtask : chk
  task automatic wt(int n);
    repeat (n) @(negedge clk_in);
  endtask : wt
  task automatic t_load(int blocked);
    int c0 = upd_cnt;
    ld_n = 1'b0;
    wt(3);
    ld_n = 1'b1;
    wt(4);
    chk("pulses", 16'(upd_cnt - c0), blocked ? 16'h0 : 16'h1);
  endtask : t_load
  task automatic t_clear(sdli_clear_sel_t s);
    logic [WORD_W-1:0] c = (s == SDLI_MIDSCALE) ? CODE_MID : CODE_ZERO;
    sel = s;
    wt(2);
    clr_n = 1'b0;
    t_load(1);
    chk("in_clr", in_reg, c);
    chk("dac_clr", dac_reg, c);
    clr_n = 1'b1;
    wt(4);
  endtask : t_clear
  task automatic t_clr_pulse();
    sel = SDLI_ZEROSCALE;
    wt(2);
    clr_n = 1'b0;
    wt(1);
    clr_n = 1'b1;
    wt(5);
    chk("in_pulse", in_reg, CODE_ZERO);
    chk("dac_pulse", dac_reg, CODE_ZERO);
  endtask : t_clr_pulse
  task automatic end_of_test();
    if (error_cnt == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : end_of_test
  initial begin
    wt(12);
    rstn_in = 1'b1;
    wt(3);
    u_host.send(16'ha5c3, 16);
    wt(6);
    chk("word", in_reg, 16'ha5c3);
    u_host.send(16'hffff, 8);
    wt(6);
    chk("short", in_reg, 16'ha5c3);
    t_load(0);
    chk("dac", dac_reg, 16'ha5c3);
    t_clear(SDLI_ZEROSCALE);
    t_clear(SDLI_MIDSCALE);
    t_clr_pulse();
    end_of_test();
  end
endmodule : sdli_top_test
bind sdli_top sdli_sva u_sva (.clk_in(clk_in), .rstn_in(rstn_in),
  .link_in(link_in), .dac_load_strobe_n_in(dac_load_strobe_n_in),
  .async_clear_n_in(async_clear_n_in), .clear_sel_in(clear_sel_in),
  .input_reg_out(input_reg_out), .dac_reg_out(dac_reg_out),
  .dac_update_out(dac_update_out));
